/* File: design/link_regs_defines.svh */
// Constants for the link capability, control and status register group
// How it works
// (RULE1) Capabilities top byte reads port number zero.
// (RULE2) Bandwidth notify, link-active report and surprise-down capability bits read zero.
// (RULE3) L1 exit latency field reads fixed code 101b.
// (RULE4) L0s exit latency field reads fixed code 101b.
// (RULE5) Power-state support field reads 01b, L0s only.
// (RULE6) Maximum link width field reads 01h, one lane.
// (RULE7) Maximum link speed field reads 0001b, 2.5 Gbps.
// (RULE8) Autonomous bandwidth enable set: status rising raises an interrupt.
// (RULE9) Bandwidth management enable set: status rising raises an interrupt.
// (RULE10) Autonomous width disable bit always reads zero.
// (RULE11) Clock power management enable forced zero when capability absent.
// (RULE12) Extended sync: 4096 FTS, one SKP, 1024 TS1; resets to zero.
// (RULE13) Software sets common clock bit to match shared reference clock.
// (RULE14) Retrain and link disable bits stored but never acted upon.
// (RULE15) Read completion boundary accepts writes but reads zero.
// (RULE16) Power-state control: 00 none, 01 L0s, 10 L1, 11 both.
// (RULE17) Slot clock status bit is strapped at reset from the platform.
// (RULE18) Link training bit reads one while training runs.
// (RULE19) Training error sets on error, clears on normal L0 entry.
// (RULE20) Negotiated width reads 000001b.
// (RULE21) Negotiated speed reads 0001b.
// (RULE22) Status bits 15 to 13 are read-only; writes ignored.
`ifndef LINK_REGS_DEFINES_SVH
`define LINK_REGS_DEFINES_SVH

`define IDX_CAP 6'h0c
`define IDX_CTRL 6'h10
`define IDX_STAT 6'h12

`define CAP_PORT_NUM 8'h00
`define CAP_L1_EXIT 3'h5
`define CAP_L0S_EXIT 3'h5
`define CAP_ASPM_SUP 2'h1
`define CAP_MAX_WIDTH 6'h01
`define CAP_MAX_SPEED 4'h1
`define STAT_NEG_WIDTH 6'h01
`define STAT_NEG_SPEED 4'h1

`define CTRL_ABW_IE 11
`define CTRL_BWM_IE 10
`define CTRL_CLKPM 8
`define CTRL_EXT_SYNC 7
`define CTRL_COMMON_CLK 6
`define CTRL_RETRAIN 5
`define CTRL_DISABLE 4

`define CTRL_RESET 16'h0000

`define EXT_FTS_COUNT 13'h1000
`define EXT_TS1_COUNT 11'h400

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: design/link_regs_pkg.sv */
// Types for the link capability, control and status register group
package link_regs_pkg;

    typedef enum logic [1:0] {
        SEL_CAP,
        SEL_CTRL,
        SEL_STAT,
        SEL_NONE
    } sel_e;

    typedef struct packed {
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic abw_ie;
        logic bwm_ie;
        logic clk_pm_en;
        logic ext_sync;
        logic common_clk;
        logic retrain;
        logic link_dis;
        logic [1:0] aspm;
        logic train_err;
        logic link_train;
        logic dll_active;
        logic abw_st;
        logic bwm_st;
        logic abw_irq;
        logic bwm_irq;
        logic [1:0] slot_sync;
        logic [1:0] clkpm_sync;
        logic slot_clk;
        logic clk_pm_cap;
        logic straps_taken;
    } regs_s;

endpackage

/* File: design/link_regs.sv */
// Link capability, control and status registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "link_regs_defines.svh"

module link_regs #(
    parameter logic [12:0] FTS_NORMAL = 13'h0ff,
    parameter logic [10:0] TS1_NORMAL = 11'h010
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Link core status, same clock
    input wire logic link_training,
    input wire logic train_error_evt,
    input wire logic l0_normal_evt,
    input wire logic dll_active,
    input wire logic abw_status,
    input wire logic bwm_status,
    // Board straps, asynchronous pins
    input wire logic slot_clk_pin,
    input wire logic clk_pm_cap_pin,
    // Link control outputs
    output logic aspm_l0s_en,
    output logic aspm_l1_en,
    output logic common_clk,
    output logic ext_sync,
    output logic clk_pm_en,
    output logic skp_before_l0,
    output logic [12:0] fts_count,
    output logic [10:0] ts1_l1_count,
    // Bandwidth interrupt requests
    output logic abw_irq,
    output logic bwm_irq
);
    import link_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    regs_s s_q;
    regs_s s_d;
    sel_e wsel;
    sel_e rsel;
    logic do_write;
    logic [15:0] ctrl_new;

    ////////////////////////////////////////////////////////////////////////

    // Address decode shared by both channels
    function automatic sel_e decode(input logic [7:0] addr);
        sel_e sel;
        if (addr == {`IDX_CAP, 2'b00}) begin
            sel = SEL_CAP;
        end else if (addr == {`IDX_CTRL, 2'b00}) begin
            sel = SEL_CTRL;
        end else if (addr == {`IDX_STAT, 2'b00}) begin
            sel = SEL_STAT;
        end else begin
            sel = SEL_NONE;
        end
        return sel;
    endfunction

    function automatic logic [31:0] cap_word(input regs_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[31:24] = `CAP_PORT_NUM; // RULE1
        w[21] = 1'b0; // RULE2
        w[20] = 1'b0; // RULE2
        w[19] = 1'b0; // RULE2
        w[18] = s.clk_pm_cap;
        w[17:15] = `CAP_L1_EXIT; // RULE3
        w[14:12] = `CAP_L0S_EXIT; // RULE4
        w[11:10] = `CAP_ASPM_SUP; // RULE5
        w[9:4] = `CAP_MAX_WIDTH; // RULE6
        w[3:0] = `CAP_MAX_SPEED; // RULE7
        return w;
    endfunction

    function automatic logic [15:0] ctrl_word(input regs_s s);
        logic [15:0] w;
        w = 16'h0000;
        w[`CTRL_ABW_IE] = s.abw_ie;
        w[`CTRL_BWM_IE] = s.bwm_ie;
        w[9] = 1'b0; // RULE10
        w[`CTRL_CLKPM] = s.clk_pm_en;
        w[`CTRL_EXT_SYNC] = s.ext_sync;
        w[`CTRL_COMMON_CLK] = s.common_clk;
        w[`CTRL_RETRAIN] = s.retrain;
        w[`CTRL_DISABLE] = s.link_dis;
        w[3] = 1'b0; // RULE15
        w[1:0] = s.aspm;
        return w;
    endfunction

    function automatic logic [15:0] stat_word(input regs_s s);
        logic [15:0] w;
        w = 16'h0000;
        w[15] = s.abw_st;
        w[14] = s.bwm_st;
        w[13] = s.dll_active;
        w[12] = s.slot_clk; // RULE17
        w[11] = s.link_train; // RULE18
        w[10] = s.train_err; // RULE19
        w[9:4] = `STAT_NEG_WIDTH; // RULE20
        w[3:0] = `STAT_NEG_SPEED; // RULE21
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    // Ready while the holding slot is empty and no response is pending
    assign awready = !s_q.aw_hold && !s_q.bvalid;
    assign wready = !s_q.w_hold && !s_q.bvalid;
    assign arready = !s_q.rvalid;

    assign wsel = decode(s_q.aw_addr);
    assign rsel = decode(araddr);
    assign do_write = s_q.aw_hold && s_q.w_hold;

    // Byte lanes 0 and 1 carry the control word
    always_comb begin
        ctrl_new = ctrl_word(s_q);
        if (s_q.w_strb[0]) begin
            ctrl_new[7:0] = s_q.w_data[7:0];
        end
        if (s_q.w_strb[1]) begin
            ctrl_new[15:8] = s_q.w_data[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        s_d = s_q;

        // Write channel capture, either order
        if (awvalid && awready) begin
            s_d.aw_hold = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            s_d.w_hold = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end

        // Commit once both halves are held
        if (do_write) begin
            s_d.aw_hold = 1'b0;
            s_d.w_hold = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `RESP_OKAY;
            unique case (wsel)
                SEL_CTRL: begin
                    s_d.abw_ie = ctrl_new[`CTRL_ABW_IE];
                    s_d.bwm_ie = ctrl_new[`CTRL_BWM_IE];
                    s_d.clk_pm_en = ctrl_new[`CTRL_CLKPM] & s_q.clk_pm_cap; // RULE11
                    s_d.ext_sync = ctrl_new[`CTRL_EXT_SYNC];
                    s_d.common_clk = ctrl_new[`CTRL_COMMON_CLK]; // RULE13
                    s_d.retrain = ctrl_new[`CTRL_RETRAIN]; // RULE14
                    s_d.link_dis = ctrl_new[`CTRL_DISABLE]; // RULE14
                    s_d.aspm = ctrl_new[1:0];
                end
                // Read-only words swallow the write quietly
                SEL_CAP, SEL_STAT: begin
                    s_d.bresp = `RESP_OKAY; // RULE22
                end
                SEL_NONE: begin
                    s_d.bresp = `RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end

        // Read: data registered one cycle after the address is taken
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `RESP_OKAY;
            unique case (rsel)
                SEL_CAP: begin
                    s_d.rdata = cap_word(s_q);
                end
                SEL_CTRL: begin
                    s_d.rdata = {16'h0000, ctrl_word(s_q)};
                end
                SEL_STAT: begin
                    s_d.rdata = {16'h0000, stat_word(s_q)};
                end
                SEL_NONE: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = `RESP_SLVERR;
                end
            endcase
        end

        // Clock power management drops if the capability strap is absent
        if (!s_q.clk_pm_cap) begin
            s_d.clk_pm_en = 1'b0; // RULE11
        end

        // Link core status follows the core, software cannot touch it
        s_d.link_train = link_training; // RULE18
        s_d.dll_active = dll_active; // RULE22
        s_d.abw_st = abw_status; // RULE22
        s_d.bwm_st = bwm_status; // RULE22

        // Error set wins over a same-cycle normal L0 entry
        if (l0_normal_evt) begin
            s_d.train_err = 1'b0; // RULE19
        end
        if (train_error_evt) begin
            s_d.train_err = 1'b1; // RULE19
        end

        // One-cycle requests on a rising status bit
        s_d.abw_irq = s_q.abw_ie && abw_status && !s_q.abw_st; // RULE8
        s_d.bwm_irq = s_q.bwm_ie && bwm_status && !s_q.bwm_st; // RULE9

        // Straps: two flops, then frozen once after reset release
        s_d.slot_sync = {s_q.slot_sync[0], slot_clk_pin};
        s_d.clkpm_sync = {s_q.clkpm_sync[0], clk_pm_cap_pin};
        if (!s_q.straps_taken) begin
            s_d.slot_clk = s_q.slot_sync[1]; // RULE17
            s_d.clk_pm_cap = s_q.clkpm_sync[1];
            s_d.straps_taken = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // Sync flops stay free running so the straps settle during reset
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.abw_ie <= 1'b0;
            s_q.ext_sync <= 1'b0; // RULE12
            s_q.slot_sync <= s_d.slot_sync;
            s_q.clkpm_sync <= s_d.clkpm_sync;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;

    // Control decode toward the link core
    assign aspm_l0s_en = s_q.aspm[0]; // RULE16
    assign aspm_l1_en = s_q.aspm[1]; // RULE16
    assign common_clk = s_q.common_clk;
    assign clk_pm_en = s_q.clk_pm_en;
    assign ext_sync = s_q.ext_sync;
    // Longer sequences trade exit time for better bit and symbol lock
    assign skp_before_l0 = s_q.ext_sync; // RULE12
    assign fts_count = s_q.ext_sync ? `EXT_FTS_COUNT : FTS_NORMAL; // RULE12
    assign ts1_l1_count = s_q.ext_sync ? `EXT_TS1_COUNT : TS1_NORMAL; // RULE12

    assign abw_irq = s_q.abw_irq;
    assign bwm_irq = s_q.bwm_irq;

endmodule

/* File: dv/link_regs_props.sv */
// Assertions on the link register block ports
`timescale 1ns/1ps
module link_regs_props #(
    parameter logic [12:0] FTS_NORMAL = 13'h0ff,
    parameter logic [10:0] TS1_NORMAL = 11'h010
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Read data
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    // Link side
    input wire logic abw_status,
    input wire logic bwm_status,
    input wire logic ext_sync,
    input wire logic skp_before_l0,
    input wire logic [12:0] fts_count,
    input wire logic [10:0] ts1_l1_count,
    input wire logic abw_irq,
    input wire logic bwm_irq
);
    logic abw_q;
    logic bwm_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Own copy of the mirrored status, so a rise is seen as the block sees it
    always_ff @(posedge clk) begin
        abw_q <= rst ? 1'b0 : abw_status;
        bwm_q <= rst ? 1'b0 : bwm_status;
    end
    fts_len_a: assert property (fts_count == (ext_sync ? 13'h1000 : FTS_NORMAL))
        else $error("fts count wrong");
    ts1_len_a: assert property (ts1_l1_count == (ext_sync ? 11'h400 : TS1_NORMAL))
        else $error("ts1 count wrong");
    skp_sync_a: assert property (skp_before_l0 == ext_sync)
        else $error("skp flag wrong");
    abw_pulse_a: assert property (abw_irq |-> $past(abw_status && !abw_q) ##1 !abw_irq)
        else $error("abw irq without rise");
    bwm_pulse_a: assert property (bwm_irq |-> $past(bwm_status && !bwm_q) ##1 !bwm_irq)
        else $error("bwm irq without rise");
    rsvd_zero_a: assert property (rvalid |-> !rdata[9] && rdata[3:2] == 2'h0)
        else $error("fixed zero bit set");
    port_num_a: assert property (rvalid |-> rdata[31:24] == 8'h00)
        else $error("port number not zero");
    cap_none_a: assert property (rvalid |-> rdata[21:19] == 3'h0)
        else $error("capability bit set");
endmodule
bind link_regs link_regs_props #(.FTS_NORMAL(FTS_NORMAL), .TS1_NORMAL(TS1_NORMAL))
    link_regs_props_inst (.clk(clk), .rst(rst), .rvalid(rvalid), .rdata(rdata),
    .abw_status(abw_status), .bwm_status(bwm_status), .ext_sync(ext_sync),
    .skp_before_l0(skp_before_l0), .fts_count(fts_count), .ts1_l1_count(ts1_l1_count),
    .abw_irq(abw_irq), .bwm_irq(bwm_irq));

/* File: dv/link_core_model.sv */
// Link core stand-in that runs training for the register block
`timescale 1ns/1ps
module link_core_model (
    // Clock
    input wire logic clk,
    // Bench commands
    input wire logic start,
    input wire logic fail,
    // Status toward the block
    output logic link_training = 1'b0,
    output logic train_error_evt = 1'b0,
    output logic l0_normal_evt = 1'b0,
    output logic dll_active = 1'b0
);
    logic [4:0] cnt_q = 5'h00;
    // Fixed 20-cycle training; events are single-cycle pulses
    always @(posedge clk) begin
        train_error_evt <= 1'b0;
        l0_normal_evt <= 1'b0;
        if (start) begin
            link_training <= 1'b1;
            dll_active <= 1'b0;
            cnt_q <= 5'h14;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end
        if (!start && cnt_q == 5'h01) begin
            link_training <= 1'b0;
            train_error_evt <= fail;
            l0_normal_evt <= !fail;
            dll_active <= !fail;
        end
    end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the link register block
`timescale 1ns/1ps
module testbench;
    localparam logic [12:0] FTS_N = 13'h020;
    localparam logic [10:0] TS1_N = 11'h008;
    logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
    logic abw_status = 0, bwm_status = 0, start = 0, fail = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, w;
    logic awready, wready, bvalid, arready, rvalid, l0s, l1, cclk, esync, cpm, skp;
    logic abw_irq, bwm_irq, training, terr, l0ok, dll;
    logic [1:0] bresp, rresp;
    logic [12:0] fts;
    logic [10:0] ts1;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    int mismatches = 0, checks = 0, abw_n = 0, bwm_n = 0, seed = 32'hbc4d;

    initial forever #12.5 clk = ~clk;

    link_regs #(.FTS_NORMAL(FTS_N), .TS1_NORMAL(TS1_N)) link_regs_inst (
        .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .link_training(training),
        .train_error_evt(terr), .l0_normal_evt(l0ok), .dll_active(dll),
        .abw_status(abw_status), .bwm_status(bwm_status), .slot_clk_pin(1'b1),
        .clk_pm_cap_pin(1'b0), .aspm_l0s_en(l0s), .aspm_l1_en(l1), .common_clk(cclk),
        .ext_sync(esync), .clk_pm_en(cpm), .skp_before_l0(skp), .fts_count(fts),
        .ts1_l1_count(ts1), .abw_irq(abw_irq), .bwm_irq(bwm_irq));
    link_core_model link_core_model_inst (.clk(clk), .start(start), .fail(fail),
        .link_training(training), .train_error_evt(terr), .l0_normal_evt(l0ok),
        .dll_active(dll));

    ////////////////////////////////////////
    task chk(input logic [33:0] g, input logic [33:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Responses are judged by the monitor; ready lines stay high throughout
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
    endtask
    task rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
    endtask
    task train(input logic f, input logic [33:0] mid, input logic [33:0] done);
        fail <= f;
        start <= 1;
        @(posedge clk);
        start <= 0;
        tick(3);
        rd(8'h48, mid);
        tick(25);
        rd(8'h48, done);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk) begin
        if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
        if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
        if (abw_irq) abw_n++;
        if (bwm_irq) bwm_n++;
    end

    initial begin
        #100000;
        mismatches++;
        stop_test;
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        tick(4);
        wr(8'h30, 32'hffffffff, 2'h0);
        wr(8'h48, 32'hffffffff, 2'h0);
        wr(8'h44, 32'h1, 2'h2);
        rd(8'h44, 34'h200000000);
        rd(8'h30, 34'h2d411);
        rd(8'h40, 34'h0);
        rd(8'h48, 34'h1011);
        for (int i = 0; i < 8; i++) begin
            w = $random(seed);
            w[1:0] = i[1:0];
            w[6] = 1'b1;
            wr(8'h40, w, 2'h0);
            rd(8'h40, {2'h0, w & 32'h0cf3});
            chk({4'h0, fts, ts1, skp, cpm, cclk, esync, l1, l0s}, {4'h0,
                (w[7] ? 13'h1000 : FTS_N), (w[7] ? 11'h400 : TS1_N), w[7], 1'b0,
                w[6], w[7], w[1:0]});
        end
        train(1'b1, 34'h1811, 34'h1411);
        train(1'b0, 34'h1c11, 34'h3011);
        wr(8'h40, 32'h0c00, 2'h0);
        abw_status <= 1;
        tick(4);
        bwm_status <= 1;
        tick(4);
        rd(8'h48, 34'hf011);
        // Enables off: a fresh rise must stay silent
        wr(8'h40, 32'h0, 2'h0);
        abw_status <= 0;
        bwm_status <= 0;
        tick(3);
        abw_status <= 1;
        tick(4);
        chk({2'h0, abw_n[15:0], bwm_n[15:0]}, 34'h10001);
        stop_test;
    end
endmodule
